// ### core/fbm_mapper.sv
// fieldbus io echo mapper: input byte 0 echo, output byte 0 control, apb config
// Functional notes
// - trigger echo puts trigger line in bit 0
// - aux echo puts input 3 in bit 2
// - phase echo puts reading phase in bit 7
// - phase echo only when start from bus
// - any echo reserves input byte 0
// - no echo: payload starts input byte 0
// - output control reserves output byte 0
// - no output control: payload at byte 0
// - output 1 follows output bit 0
// - output 2 follows output bit 1
// - control only when use selects fieldbus
//
// Chosen here: the placing of the registers and register access over APB.
`include "fbm_map.svh"
module fbm_mapper (
   input  wire logic              pclk,          // system clock, 125 MHz
   input  wire logic              presetn,       // async reset, active low
   input  wire logic              psel,          // apb select
   input  wire logic              penable,       // apb access phase
   input  wire logic              pwrite,        // apb write
   input  wire logic [11:0]       paddr,         // apb byte address
   input  wire logic [31:0]       pwdata,        // apb write data
   input  wire logic [3:0]        pstrb,         // apb byte strobes
   output logic      [31:0]       prdata,        // apb read data
   output logic                   pready,        // apb ready
   output logic                   pslverr,       // apb error on unmapped address
   input  wire logic [2:0]        din_pins,      // digital inputs 1..3 from pins
   input  wire logic              phase_active,  // reading phase, same clock domain
   input  wire logic              obyte_valid,   // new output byte 0 from master
   input  wire logic [7:0]        obyte,         // output area byte 0 from master
   output fbm_pkg::fbm_frame_t    frame,         // framing for payload driver
   output logic                   dout1,         // digital output 1 from bus
   output logic                   dout2,         // digital output 2 from bus
   output logic                   dout1_bus,     // output 1 owned by fieldbus
   output logic                   dout2_bus      // output 2 owned by fieldbus
);
   import fbm_pkg::*;

   // synchronised input lines
   logic [`FBM_DIN_WIDTH-1:0] din_s;            // pins after two flops

   fbm_sync #(
      .W (`FBM_DIN_WIDTH)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d_async (din_pins),
      .q_sync  (din_s)
   );

   // configuration state
   fbm_cfg_t    cfg_reg;         // software configuration
   fbm_cfg_t    cfg_next;
   logic [7:0]  obyte_reg;       // latest output byte 0 from master
   logic [7:0]  obyte_next;
   logic [31:0] prdata_reg;      // registered read data
   logic [31:0] prdata_next;
   logic        pslverr_reg;     // registered error answer
   logic        pslverr_next;
   fbm_frame_t  frame_reg;       // registered framing
   fbm_frame_t  frame_next;
   logic        dout1_reg;       // registered output 1
   logic        dout1_next;
   logic        dout2_reg;       // registered output 2
   logic        dout2_next;

   // decoded effective enables
   logic        phase_eff;       // phase echo actually in force
   logic        oc1_eff;         // output 1 control actually in force
   logic        oc2_eff;         // output 2 control actually in force
   logic        in_res;          // input byte 0 reserved
   logic        out_res;         // output byte 0 reserved
   logic [7:0]  echo;            // echo byte under construction
   logic        access;          // apb access phase strobe
   logic        hit_cfg;         // address hits configuration word
   logic        hit_stat;        // address hits status word
   logic        hit_obyte;       // address hits output byte word

   // effective options; setting is stored but masked when its source is wrong
   always_comb begin
      phase_eff = cfg_reg.phase_en & cfg_reg.start_bus;
      oc1_eff   = cfg_reg.oc1_en & cfg_reg.use1_bus;
      oc2_eff   = cfg_reg.oc2_en & cfg_reg.use2_bus;
      in_res    = cfg_reg.trig_en | cfg_reg.aux_en | phase_eff;
      out_res   = oc1_eff | oc2_eff;
   end

   // echo byte: bits of disabled options stay zero
   always_comb begin
      echo = `FBM_BYTE_ZERO;
      echo[`FBM_IN_TRIG_BIT]  = cfg_reg.trig_en & din_s[`FBM_DIN_TRIG];
      echo[`FBM_IN_AUX_BIT]   = cfg_reg.aux_en & din_s[`FBM_DIN_AUX];
      echo[`FBM_IN_PHASE_BIT] = phase_eff & phase_active;
   end

   // apb decode; single-cycle access phase, no wait states
   always_comb begin
      access    = psel & penable;
      hit_cfg   = (paddr == `FBM_CFG_OFS);
      hit_stat  = (paddr == `FBM_STAT_OFS);
      hit_obyte = (paddr == `FBM_OBYTE_OFS);
   end

   // next state for configuration, read data and error answer
   always_comb begin
      cfg_next     = cfg_reg;
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      if (psel & ~penable) begin
         // setup: prepare the answer so it stands in the access cycle
         pslverr_next = ~(hit_cfg | hit_stat | hit_obyte);
         prdata_next  = 32'h0000_0000;
         if (!pwrite) begin
            if (hit_cfg) begin
               prdata_next[`FBM_CFG_WIDTH-1:0] = cfg_reg;
            end else if (hit_stat) begin
               prdata_next[`FBM_BYTE_MSB:0]         = frame_reg.in_byte0;
               prdata_next[`FBM_STAT_INRES_BIT]     = frame_reg.in_reserved;
               prdata_next[`FBM_STAT_OUTRES_BIT]    = frame_reg.out_reserved;
               prdata_next[`FBM_STAT_DO1_BIT]       = dout1_reg;
               prdata_next[`FBM_STAT_DO2_BIT]       = dout2_reg;
               prdata_next[`FBM_STAT_DIN_MSB:`FBM_STAT_DIN_LSB] = din_s;
            end else if (hit_obyte) begin
               prdata_next[`FBM_BYTE_MSB:0] = obyte_reg;
            end
         end
      end else if (access) begin
         pslverr_next = pslverr_reg;
         // write takes effect only on the completing edge
         if (pwrite && hit_cfg && pstrb[0]) begin
            cfg_next = fbm_cfg_t'(pwdata[`FBM_CFG_WIDTH-1:0]);
         end
      end
   end

   // output area byte 0 capture; only reserved byte steers outputs
   always_comb begin
      obyte_next = obyte_reg;
      if (obyte_valid) begin
         obyte_next = obyte;
      end
   end

   // framing and digital outputs; other bits of obyte are ignored
   always_comb begin
      frame_next.in_reserved  = in_res;
      frame_next.out_reserved = out_res;
      frame_next.in_byte0     = in_res ? echo : `FBM_BYTE_ZERO;
      dout1_next = oc1_eff & obyte_reg[`FBM_OUT_DO1_BIT];
      dout2_next = oc2_eff & obyte_reg[`FBM_OUT_DO2_BIT];
   end

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg     <= fbm_cfg_t'(`FBM_CFG_RESET);
         obyte_reg   <= `FBM_BYTE_ZERO;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
         frame_reg   <= '0;
         dout1_reg   <= 1'b0;
         dout2_reg   <= 1'b0;
      end else begin
         cfg_reg     <= cfg_next;
         obyte_reg   <= obyte_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
         frame_reg   <= frame_next;
         dout1_reg   <= dout1_next;
         dout2_reg   <= dout2_next;
      end
   end

   // outputs; ownership flags are combinational so the output mux flips at once
   assign prdata    = prdata_reg;
   assign pready    = 1'b1;
   assign pslverr   = pslverr_reg & access;
   assign frame     = frame_reg;
   assign dout1     = dout1_reg;
   assign dout2     = dout2_reg;
   assign dout1_bus = oc1_eff;
   assign dout2_bus = oc2_eff;
endmodule

// ### core/fbm_map.svh
// register offsets, field positions and reset values of the fieldbus echo mapper
`ifndef FBM_MAP_SVH
`define FBM_MAP_SVH
`define FBM_CFG_OFS       12'h000
`define FBM_STAT_OFS      12'h004
`define FBM_OBYTE_OFS     12'h008
`define FBM_CFG_RESET     8'h00
`define FBM_CFG_TRIG_BIT  0
`define FBM_CFG_AUX_BIT   1
`define FBM_CFG_PHASE_BIT 2
`define FBM_CFG_BUSST_BIT 3
`define FBM_CFG_OC1_BIT   4
`define FBM_CFG_OC2_BIT   5
`define FBM_CFG_USE1_BIT  6
`define FBM_CFG_USE2_BIT  7
`define FBM_CFG_WIDTH     8
`define FBM_IN_TRIG_BIT   0
`define FBM_IN_AUX_BIT    2
`define FBM_IN_PHASE_BIT  7
`define FBM_OUT_DO1_BIT   0
`define FBM_OUT_DO2_BIT   1
`define FBM_BYTE_ZERO     8'h00
`define FBM_DIN_WIDTH     3
`define FBM_DIN_TRIG      0
`define FBM_DIN_AUX       2
`define FBM_BYTE_MSB        7
`define FBM_STAT_INRES_BIT  8
`define FBM_STAT_OUTRES_BIT 9
`define FBM_STAT_DO1_BIT    10
`define FBM_STAT_DO2_BIT    11
`define FBM_STAT_DIN_LSB    12
`define FBM_STAT_DIN_MSB    14
`endif

// ### core/fbm_pkg.sv
// types shared by the fieldbus echo mapper
package fbm_pkg;
   // configuration fields carried as one packed group
   typedef struct packed {
      logic use2_bus;    // output 2 source is the fieldbus
      logic use1_bus;    // output 1 source is the fieldbus
      logic oc2_en;      // output 2 control enable
      logic oc1_en;      // output 1 control enable
      logic start_bus;   // reading-phase start taken from the fieldbus
      logic phase_en;    // phase echo enable
      logic aux_en;      // aux input echo enable
      logic trig_en;     // trigger echo enable
   } fbm_cfg_t;
   // area framing towards the payload driver
   typedef struct packed {
      logic       in_reserved;   // input byte 0 reserved for echo
      logic       out_reserved;  // output byte 0 reserved for control
      logic [7:0] in_byte0;      // echo byte for input area
   } fbm_frame_t;
endpackage

// ### core/fbm_sync.sv
// two-flop synchroniser for a group of asynchronous input lines
module fbm_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,     // system clock
   input  wire logic         presetn,  // async reset, active low
   input  wire logic [W-1:0] d_async,  // lines from pins
   output logic      [W-1:0] q_sync    // synchronised lines
);
   logic [W-1:0] meta_reg;  // first stage, read only by the second
   logic [W-1:0] sync_reg;  // second stage
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_next;

   // next values: shift one stage
   always_comb begin
      meta_next = d_async;
      sync_next = meta_reg;
   end

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign q_sync = sync_reg;
endmodule

// ### tb/fbm_mapper_sva.sv
// port-level assertions of the echo mapper
module fbm_mapper_sva (
   input wire logic                pclk,          // clock
   input wire logic                presetn,       // reset, active low
   input wire logic [2:0]          din_pins,      // input pins
   input wire logic                phase_active,  // reading phase
   input wire logic                obyte_valid,   // byte strobe
   input wire logic [7:0]          obyte,         // output byte 0
   input wire fbm_pkg::fbm_frame_t frame,         // framing
   input wire logic                dout1,         // output 1
   input wire logic                dout2,         // output 2
   input wire logic                dout1_bus,     // output 1 owned
   input wire logic                dout2_bus      // output 2 owned
);
   timeunit 1ns;
   timeprecision 1ps;
   import fbm_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // pins pass two sync flops and one register, hence depth 3
   property p_trig; frame.in_byte0[0] |-> $past(din_pins[0], 3); endproperty
   a_trig: assert property (p_trig) else $error("trigger echo wrong");
   property p_aux; frame.in_byte0[2] |-> $past(din_pins[2], 3); endproperty
   a_aux: assert property (p_aux) else $error("aux echo wrong");
   property p_phase; frame.in_byte0[7] |-> $past(phase_active); endproperty
   a_phase: assert property (p_phase) else $error("phase echo wrong");
   property p_rsv; frame.in_byte0 != 8'h00 |-> frame.in_reserved; endproperty
   a_rsv: assert property (p_rsv) else $error("echo bits without reservation");
   property p_none; !frame.in_reserved |-> frame.in_byte0 == 8'h00; endproperty
   a_none: assert property (p_none) else $error("byte 0 used unreserved");
   property p_zero; frame.in_byte0[6:3] == 4'h0 && !frame.in_byte0[1]; endproperty
   a_zero: assert property (p_zero) else $error("unused echo bit set");
   // ownership is combinational, framing registered: allow one cycle
   property p_out; (dout1_bus || dout2_bus) [*2] |-> frame.out_reserved; endproperty
   a_out: assert property (p_out) else $error("output byte 0 not reserved");
   property p_o1;
      obyte_valid && dout1_bus ##1 dout1_bus [*2] |-> dout1 == $past(obyte[0], 2);
   endproperty
   a_o1: assert property (p_o1) else $error("output 1 not from bit 0");
   property p_o2;
      obyte_valid && dout2_bus ##1 dout2_bus [*2] |-> dout2 == $past(obyte[1], 2);
   endproperty
   a_o2: assert property (p_o2) else $error("output 2 not from bit 1");
   property p_own; !dout1_bus [*2] |-> !dout1; endproperty
   a_own: assert property (p_own) else $error("output 1 driven without ownership");
   property p_own2; !dout2_bus [*2] |-> !dout2; endproperty
   a_own2: assert property (p_own2) else $error("output 2 driven without ownership");
   c_echo: cover property (frame.in_reserved && frame.in_byte0[7]);
   c_out1: cover property (dout1 && frame.out_reserved);
   c_out2: cover property (dout2);
endmodule
bind fbm_mapper fbm_mapper_sva i_sva (.pclk(pclk), .presetn(presetn), .din_pins(din_pins),
   .phase_active(phase_active), .obyte_valid(obyte_valid), .obyte(obyte), .frame(frame),
   .dout1(dout1), .dout2(dout2), .dout1_bus(dout1_bus), .dout2_bus(dout2_bus));

// ### tb/fbm_master_model.sv
// fieldbus master model driving output area byte 0
module fbm_master_model (
   input  wire logic pclk,         // system clock
   output logic       obyte_valid, // byte 0 strobe
   output logic [7:0] obyte        // output area byte 0
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle byte is junk so a stale value is never taken for fresh data
   initial begin
      obyte_valid = 1'b0;
      obyte       = 8'h5a;
   end
   // bit 0 drives output 1, bit 1 output 2
   task automatic send(input logic [7:0] b);
      @(posedge pclk);
      obyte_valid <= 1'b1;
      obyte       <= b;
      @(posedge pclk);
      obyte_valid <= 1'b0;
      obyte       <= ~b; // released byte shows the inverse
   endtask
endmodule

// ### tb/testbench.sv
// self-checking bench of the echo mapper
`include "fbm_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import fbm_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        phase_active, obyte_valid, dout1, dout2, dout1_bus, dout2_bus;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  din_pins;
   logic [7:0]  obyte, c, e;
   fbm_frame_t  frame;
   int          err_total, checks;
   int          cyc = 0;
   logic [7:0]  ect [6] = '{8'h01, 8'h02, 8'h04, 8'h0c, 8'h0f, 8'h00}; // echo cfgs
   logic [7:0]  oct [4] = '{8'h30, 8'h50, 8'ha0, 8'hf0}; // output cfgs
   always #4 pclk = ~pclk;
   fbm_mapper i_fbm_mapper (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .din_pins(din_pins), .phase_active(phase_active),
      .obyte_valid(obyte_valid), .obyte(obyte), .frame(frame), .dout1(dout1),
      .dout2(dout2), .dout1_bus(dout1_bus), .dout2_bus(dout2_bus));
   fbm_master_model i_fbm_master_model (.pclk(pclk), .obyte_valid(obyte_valid),
      .obyte(obyte));
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic end_sim;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // apb transfer; leading edge keeps two transfers from touching psel in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the hang guard ends a wait for pready
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wcfg(input logic [7:0] v);
      apb(1'b1, `FBM_CFG_OFS, {24'h0, v});
      repeat (4) @(posedge pclk); // let sync and framing settle
   endtask
   // hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      din_pins = 0; phase_active = 0; err_total = 0; checks = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `FBM_CFG_OFS, 0);
      chk(rd, {24'h0, `FBM_CFG_RESET});
      chk({22'h0, frame}, 32'h0);
      apb(1'b0, 12'h00c, 0);
      chk(er, 1'b1); // unmapped place refused
      $display("test reset done");
      // phase high with start from bus off must stay hidden
      for (int i = 0; i < 6; i++) begin
         c = ect[i];
         din_pins <= (i == 4) ? 3'b010 : 3'b111;
         phase_active <= (i != 4);
         wcfg(c);
         e = {c[2] & c[3] & phase_active, 4'h0, c[1] & din_pins[2], 1'b0, c[0] & din_pins[0]};
         chk(frame.in_byte0, e);
         chk(frame.in_reserved, c[0] | c[1] | (c[2] & c[3]));
         apb(1'b0, `FBM_STAT_OFS, 0);
         chk(rd, {17'h0, din_pins, 3'b000, c[0] | c[1] | (c[2] & c[3]), e});
      end
      $display("test echo done");
      // control enable without fieldbus use must be ignored
      for (int i = 0; i < 4; i++) begin
         c = oct[i];
         wcfg(c);
         chk({dout2_bus, dout1_bus}, {c[5] & c[7], c[4] & c[6]});
         for (int j = 0; j < 2; j++) begin
            e = j ? 8'hfe : 8'hfd;
            i_fbm_master_model.send(e);
            repeat (3) @(posedge pclk);
            chk({dout2, dout1}, {c[5] & c[7] & e[1], c[4] & c[6] & e[0]});
            chk(frame.out_reserved, (c[4] & c[6]) | (c[5] & c[7]));
            apb(1'b0, `FBM_OBYTE_OFS, 0);
            chk(rd, {24'h0, e});
         end
      end
      $display("test outputs done");
      end_sim();
   end
endmodule
